/* src/sic_regs.svh */
// Register offsets, reset values and timing counts for the stack and interrupt control
`ifndef SIC_REGS_SVH
`define SIC_REGS_SVH
`define SIC_SPL_OFFSET      6'h3D
`define SIC_SPH_OFFSET      6'h3E
`define SIC_STATUS_REGISTER_OFFSET     6'h3F
`define SIC_STATUS_REGISTER_I_BIT      7
`define SIC_SP_RESET        16'h0000
`define SIC_SP_LAST_SRAM    16'h045F
`define SIC_ENTRY_CYCLES    3'h4
`define SIC_WAKE_CYCLES     3'h4
`define SIC_RETURN_CYCLES   3'h4
`define SIC_NUM_IRQ         8
`define SIC_VEC_STEP        12'h001
`endif

/* src/sic_pkg.sv */
// Types for the stack and interrupt control
package sic_pkg;
	typedef enum logic [2:0] {
		SIC_IDLE,
		SIC_WAKE,
		SIC_ENTRY,
		SIC_RETURN
	} sic_state_t;
endpackage

/* src/sic_core.sv */
// Stack pointer and interrupt vectoring logic of the CPU core
// Operation
// (RQ1) Stack grows downward, pointer marks top
// (RQ2) Push stores byte, pointer minus one
// (RQ3) Call or entry saves address, minus two
// (RQ4) Pop fetches byte, pointer plus one
// (RQ5) Return restores address, pointer plus two
// (RQ6) Pointer held in I/O 0x3E/0x3D
// (RQ7) Software sets pointer before calls/interrupts
// (RQ8) Take interrupt only with both enables
// (RQ9) Vectors lowest, lower address higher priority
// (RQ10) Vector select moves vectors to boot
// (RQ11) Boot reset fuse moves reset vector
// (RQ12) Lock bits suppress interrupts by PC
// (RQ13) Entry clears global enable; nesting allowed
// (RQ14) Interrupt return sets global enable
// (RQ15) Flag interrupts cleared when vectored
// (RQ16) Write one clears flag, zero ignored
// (RQ17) Disabled flag events stay latched
// (RQ18) Level interrupts request only while present
// (RQ19) One instruction after return before next
// (RQ20) Status register never saved or restored
// (RQ21) Global disable blocks same-cycle interrupts
// (RQ22) Instruction after enable runs first
// (RQ23) Entry four cycles, sleep adds four
// (RQ24) Multi-cycle instruction completes first
// (RQ25) Return four cycles, pop two bytes
// (RQ26) Pointer reset value selectable by parameter
`timescale 1ns/100ps
`include "sic_regs.svh"
module sic_core #(
	parameter bit SP_RESET_LAST_SRAM = 1'b0
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// I/O register port
	input  wire logic [5:0]  io_addr_in,
	input  wire logic        io_wr_in,
	input  wire logic        io_rd_in,
	input  wire logic [7:0]  io_wdata_in,
	output logic      [7:0]  io_rdata_out,
	// Stack operations from the sequencer
	input  wire logic        push_in,
	input  wire logic        pop_in,
	input  wire logic        call_in,
	input  wire logic        ret_in,
	input  wire logic        irq_return_instr_in,
	input  wire logic        sei_in,
	input  wire logic        cli_in,
	input  wire logic        instr_done_in,
	input  wire logic        sleeping_in,
	input  wire logic [11:0] pc_in,
	// Interrupt sources and controls
	input  wire logic [7:0]  flag_event_in,
	input  wire logic [7:0]  level_cond_in,
	input  wire logic [7:0]  is_level_in,
	input  wire logic [7:0]  irq_enable_in,
	input  wire logic [7:0]  flag_clear_wr_in,
	input  wire logic        vector_select_in,
	input  wire logic        boot_reset_fuse_in,
	input  wire logic        app_lock_bit_in,
	input  wire logic        boot_lock_bit_in,
	input  wire logic [11:0] boot_start_in,
	// Results
	output logic [15:0] stack_addr_out,
	output logic        stack_wr_out,
	output logic        stack_rd_out,
	output logic [15:0] stack_pointer_out,
	output logic        global_enable_out,
	output logic [7:0]  pending_flags_out,
	output logic        irq_take_out,
	output logic        busy_out,
	output logic [11:0] vector_addr_out,
	output logic [11:0] reset_vector_out
);

	localparam logic [15:0] SP_INIT = SP_RESET_LAST_SRAM ? `SIC_SP_LAST_SRAM : `SIC_SP_RESET;

	sic_pkg::sic_state_t state_r;
	logic [15:0] stack_pointer_r;
	logic        gie_r;
	logic [7:0]  flags_r;
	logic [2:0]  cnt_r;
	logic        hold_r;
	logic [2:0]  sel_r;
	logic [7:0]  req;
	logic        any_req;
	logic [2:0]  sel;
	logic        locked;
	logic        take;

	// Wait reasons, last return cycle and next pointer
	logic        blocked;
	logic        ret_done;
	logic [15:0] stack_pointer_nxt;

	// Lowest index wins
	function automatic logic [2:0] prio(input logic [7:0] r);
		prio = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (r[i]) begin
				prio = 3'(i);
			end
		end
	endfunction

	// Vector base at zero or boot start
	function automatic logic [11:0] vec_base(input logic boot, input logic [11:0] b);
		vec_base = boot ? b : 12'h000;
	endfunction

	// Stack pointer moved up or down by a step
	function automatic logic [15:0] sp_move(input logic [15:0] p, input logic up,
		input logic [15:0] n);
		sp_move = up ? p + n : p - n;
	endfunction

	// Reasons a request must wait this cycle
	always_comb begin
		locked = (app_lock_bit_in && pc_in < boot_start_in)
			|| (boot_lock_bit_in && pc_in >= boot_start_in); // RQ12
		blocked = cli_in || hold_r || !instr_done_in || locked; // RQ21 RQ22 RQ19 RQ24
		blocked = blocked || state_r != sic_pkg::SIC_IDLE; // RQ24
	end

	// Requests from latched flags and present levels
	always_comb begin
		req = (is_level_in & level_cond_in) | (~is_level_in & flags_r); // RQ18 RQ17
		req = req & irq_enable_in;
		any_req = |req;
		sel = prio(req); // RQ9
		take = any_req && gie_r && !blocked; // RQ8
	end

	// Last cycle of an interrupt return
	assign ret_done = state_r == sic_pkg::SIC_RETURN && cnt_r == `SIC_RETURN_CYCLES;

	// Sequencer state
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r <= sic_pkg::SIC_IDLE;
		end else begin
			unique case (state_r)
				sic_pkg::SIC_IDLE: begin
					if (take) begin
						state_r <= sleeping_in ? sic_pkg::SIC_WAKE : sic_pkg::SIC_ENTRY; // RQ23
					end else if (irq_return_instr_in) begin
						state_r <= sic_pkg::SIC_RETURN;
					end
				end
				sic_pkg::SIC_WAKE: begin
					if (cnt_r == `SIC_WAKE_CYCLES) begin
						state_r <= sic_pkg::SIC_ENTRY; // RQ23
					end
				end
				sic_pkg::SIC_ENTRY: begin
					if (cnt_r == `SIC_ENTRY_CYCLES) begin
						state_r <= sic_pkg::SIC_IDLE; // RQ23
					end
				end
				sic_pkg::SIC_RETURN: begin
					if (ret_done) begin
						state_r <= sic_pkg::SIC_IDLE; // RQ25
					end
				end
			endcase
		end
	end

	// Cycle counter; restarts at one on each new phase
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r <= 3'h0;
		end else if (state_r == sic_pkg::SIC_IDLE) begin
			cnt_r <= 3'h1;
		end else if (state_r == sic_pkg::SIC_WAKE && cnt_r == `SIC_WAKE_CYCLES) begin
			cnt_r <= 3'h1;
		end else begin
			cnt_r <= cnt_r + 3'h1;
		end
	end

	// Source captured at acceptance selects the vector
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sel_r <= 3'h0;
		end else if (take) begin
			sel_r <= sel;
		end
	end

	// One instruction must pass after return or enable
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			hold_r <= 1'b0;
		end else if (ret_done || sei_in) begin
			hold_r <= 1'b1; // RQ19 RQ22
		end else if (instr_done_in) begin
			hold_r <= 1'b0;
		end
	end

	// Global enable: entry clears, return and enable set
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			gie_r <= 1'b0;
		end else if (take || cli_in) begin
			gie_r <= 1'b0; // RQ13 RQ21
		end else if (ret_done) begin
			gie_r <= 1'b1; // RQ14 RQ25
		end else if (sei_in) begin
			gie_r <= 1'b1;
		end else if (io_wr_in && io_addr_in == `SIC_STATUS_REGISTER_OFFSET) begin
			gie_r <= io_wdata_in[`SIC_STATUS_REGISTER_I_BIT]; // RQ13 RQ20
		end
	end

	// Pending flags; a new event wins over any clear
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			flags_r <= 8'h00;
		end else begin
			for (int i = 0; i < `SIC_NUM_IRQ; i++) begin
				if (flag_event_in[i]) begin
					flags_r[i] <= 1'b1; // RQ17
				end else if (flag_clear_wr_in[i]) begin
					flags_r[i] <= 1'b0; // RQ16
				end else if (take && !is_level_in[i] && sel == 3'(i)) begin
					flags_r[i] <= 1'b0; // RQ15
				end
			end
		end
	end

	// Next stack pointer; entry and return outrank the sequencer
	always_comb begin
		stack_pointer_nxt = stack_pointer_r;
		if (state_r == sic_pkg::SIC_ENTRY && cnt_r == 3'h1) begin
			stack_pointer_nxt = sp_move(stack_pointer_r, 1'b0, 16'h0002); // RQ3
		end else if (state_r == sic_pkg::SIC_RETURN && cnt_r == 3'h1) begin
			stack_pointer_nxt = sp_move(stack_pointer_r, 1'b1, 16'h0002); // RQ5 RQ25
		end else if (push_in) begin
			stack_pointer_nxt = sp_move(stack_pointer_r, 1'b0, 16'h0001); // RQ2 RQ1
		end else if (pop_in) begin
			stack_pointer_nxt = sp_move(stack_pointer_r, 1'b1, 16'h0001); // RQ4
		end else if (call_in) begin
			stack_pointer_nxt = sp_move(stack_pointer_r, 1'b0, 16'h0002); // RQ3
		end else if (ret_in) begin
			stack_pointer_nxt = sp_move(stack_pointer_r, 1'b1, 16'h0002); // RQ5
		end else if (io_wr_in && io_addr_in == `SIC_SPL_OFFSET) begin
			stack_pointer_nxt[7:0] = io_wdata_in; // RQ6
		end else if (io_wr_in && io_addr_in == `SIC_SPH_OFFSET) begin
			stack_pointer_nxt[15:8] = io_wdata_in; // RQ6
		end
	end

	// Stack pointer register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			stack_pointer_r <= SP_INIT; // RQ26
		end else begin
			stack_pointer_r <= stack_pointer_nxt;
		end
	end

	// Read data for I/O reads; only the I bit is held here
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			io_rdata_out <= 8'h00;
		end else if (io_rd_in) begin
			unique case (io_addr_in)
				`SIC_SPL_OFFSET:  io_rdata_out <= stack_pointer_r[7:0]; // RQ6
				`SIC_SPH_OFFSET:  io_rdata_out <= stack_pointer_r[15:8];
				`SIC_STATUS_REGISTER_OFFSET: io_rdata_out <= {gie_r, 7'h00};
				default:          io_rdata_out <= 8'h00;
			endcase
		end
	end

	// Stack memory strobes: push writes at pointer, pop reads above it
	always_comb begin
		stack_wr_out   = push_in || call_in || (state_r == sic_pkg::SIC_ENTRY && cnt_r <= 3'h2);
		stack_rd_out   = pop_in || ret_in || (state_r == sic_pkg::SIC_RETURN && cnt_r <= 3'h2);
		stack_addr_out = stack_rd_out ? stack_pointer_r + 16'h0001 : stack_pointer_r; // RQ1
	end

	// Vector outputs
	assign vector_addr_out  = vec_base(vector_select_in, boot_start_in)
		+ 12'((sel_r + 4'h1) * 2); // RQ10 RQ9
	assign reset_vector_out = vec_base(boot_reset_fuse_in, boot_start_in); // RQ11

	// Register views and status
	assign stack_pointer_out = stack_pointer_r;
	assign global_enable_out = gie_r;
	assign pending_flags_out = flags_r;
	assign irq_take_out      = take;
	assign busy_out          = state_r != sic_pkg::SIC_IDLE; // RQ24

endmodule

/* dv/sic_chk.sv */
// Checker for the stack and interrupt control
`timescale 1ns/100ps
module sic_chk (
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic        push_in,
	input wire logic        pop_in,
	input wire logic        irq_return_instr_in,
	input wire logic        cli_in,
	input wire logic        instr_done_in,
	input wire logic        sleeping_in,
	input wire logic [15:0] stack_pointer_out,
	input wire logic        global_enable_out,
	input wire logic        irq_take_out,
	input wire logic        busy_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic q;
	// Idle and no entry this cycle
	assign q = !busy_out && !irq_take_out;
	a_push_dec: assert property (push_in && q |=>
		stack_pointer_out == $past(stack_pointer_out) - 16'h0001) else $error("push step wrong");
	a_pop_inc: assert property (pop_in && q && !push_in |=>
		stack_pointer_out == $past(stack_pointer_out) + 16'h0001) else $error("pop step wrong");
	a_take_gated: assert property (irq_take_out |->
		global_enable_out && !cli_in && instr_done_in && !busy_out) else $error("bad take");
	a_entry_clears: assert property (irq_take_out |=> !global_enable_out)
		else $error("enable kept on entry");
	a_entry_time: assert property (irq_take_out && !sleeping_in |=>
		busy_out [*4] ##1 !busy_out) else $error("entry length wrong");
	a_entry_sp: assert property (irq_take_out && !sleeping_in |=> ##1
		stack_pointer_out == $past(stack_pointer_out, 2) - 16'h0002) else $error("entry sp");
	a_wake_time: assert property (irq_take_out && sleeping_in |=>
		busy_out [*8] ##1 !busy_out) else $error("wake entry length wrong");
	a_irq_return_instr_time: assert property (irq_return_instr_in && !busy_out |=>
		busy_out [*4] ##1 (global_enable_out && !busy_out)) else $error("return wrong");
	a_irq_return_instr_sp: assert property (irq_return_instr_in && !busy_out |=> ##1
		stack_pointer_out == $past(stack_pointer_out, 2) + 16'h0002) else $error("return sp");
	c_take: cover property (irq_take_out);
	c_irq_return_instr: cover property (irq_return_instr_in && !busy_out);
	c_push: cover property (push_in && q);
	c_wake: cover property (irq_take_out && sleeping_in);
endmodule
bind sic_core sic_chk u_sic_chk (.*);

/* dv/sic_seq_model.sv */
// Sequencer model giving instruction boundaries
`timescale 1ns/100ps
module sic_seq_model (
	input  wire logic clk_in,
	input  wire logic stall_in,
	output logic      instr_done_out
);
	// Boundary each cycle unless a long instruction stalls
	always_ff @(posedge clk_in) begin
		instr_done_out <= !stall_in;
	end
endmodule

/* dv/tb_top.sv */
// Testbench for the stack and interrupt control
`timescale 1ns/100ps
module tb_top;
	logic        clk_in, rst_in, io_wr_in, io_rd_in, sleeping_in, vector_select_in, stall, hit;
	logic        boot_reset_fuse_in, app_lock_bit_in, boot_lock_bit_in, instr_done_in;
	logic        push_in, pop_in, call_in, ret_in, irq_return_instr_in, sei_in, cli_in;
	logic        stack_wr_out, stack_rd_out, global_enable_out, irq_take_out, busy_out;
	logic [5:0]  io_addr_in;
	logic [7:0]  io_wdata_in, io_rdata_out, flag_event_in, level_cond_in, is_level_in;
	logic [7:0]  irq_enable_in, flag_clear_wr_in, pending_flags_out;
	logic [11:0] pc_in, boot_start_in, vector_addr_out, reset_vector_out;
	logic [15:0] stack_addr_out, stack_pointer_out;
	logic [6:0]  op;
	int          num_errors, comparisons;
	assign {push_in, pop_in, call_in, ret_in, irq_return_instr_in, sei_in, cli_in} = op;
	sic_core u_sic_core (.*);
	sic_seq_model u_sic_seq_model (.clk_in(clk_in), .stall_in(stall), .instr_done_out(instr_done_in));
	// Clock
	initial clk_in = 0;
	always #25 clk_in = ~clk_in;
	// Compare and count
	task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", n, exp, got);
		end
	endtask
	task results;
		if (num_errors == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// One-cycle sequencer pulse
	task pulse(input logic [6:0] o);
		@(posedge clk_in) op <= o;
		@(posedge clk_in) op <= '0;
		#1;
	endtask
	task wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_in) {io_addr_in, io_wdata_in, io_wr_in} <= {a, d, 1'b1};
		@(posedge clk_in) io_wr_in <= 0;
	endtask
	task rd(input string n, input logic [5:0] a, input logic [7:0] e);
		@(posedge clk_in) {io_addr_in, io_rd_in} <= {a, 1'b1};
		@(posedge clk_in) io_rd_in <= 0;
		#1 chk(n, {8'h00, io_rdata_out}, {8'h00, e});
	endtask
	// Bounded watch for an accepted interrupt
	task wt(input logic e);
		hit = 0;
		repeat (12) @(posedge clk_in) #1 if (irq_take_out === 1'b1) hit = 1;
		chk("take", {15'h0000, hit}, {15'h0000, e});
	endtask
	// Main sequence
	initial begin
		rst_in = 1;
		{op, io_wr_in, io_rd_in, sleeping_in, vector_select_in, boot_reset_fuse_in} = '0;
		{app_lock_bit_in, boot_lock_bit_in, stall, io_addr_in, io_wdata_in, flag_event_in} = '0;
		{level_cond_in, is_level_in, irq_enable_in, flag_clear_wr_in, pc_in, boot_start_in} = '0;
		num_errors = 0;
		comparisons = 0;
		repeat (6) @(posedge clk_in);
		rst_in <= 0;
		rd("sp_low", 6'h3D, 8'h00);
		rd("sp_high", 6'h3E, 8'h00);
		wr(6'h3E, 8'h04);
		wr(6'h3D, 8'h00);
		rd("sp_high", 6'h3E, 8'h04);
		for (int i = 0; i < 4; i++) begin
			pulse(7'h40 >> i);
			chk("sp", stack_pointer_out, 16'(64'h03FF_0400_03FE_0400 >> (48 - 16 * i)));
		end
		@(posedge clk_in) op <= 7'h40;
		#1 chk("stack_wr", {15'h0000, stack_wr_out}, 16'h0001);
		chk("stack_addr", stack_addr_out, 16'h0400);
		@(posedge clk_in) op <= 7'h20;
		#1 chk("stack_rd", {15'h0000, stack_rd_out}, 16'h0001);
		chk("stack_addr", stack_addr_out, 16'h0400);
		@(posedge clk_in) op <= '0;
		@(posedge clk_in) {irq_enable_in, app_lock_bit_in, stall} <= {8'h02, 2'b11};
		{boot_start_in, vector_select_in} <= {12'h800, 1'b1};
		@(posedge clk_in) {flag_event_in, boot_reset_fuse_in} <= {8'h03, 1'b1};
		@(posedge clk_in) {flag_event_in, flag_clear_wr_in} <= {8'h00, 8'h01};
		@(posedge clk_in) flag_clear_wr_in <= 0;
		#1 chk("pending", {8'h00, pending_flags_out}, 16'h0002);
		chk("reset_vec", {4'h0, reset_vector_out}, 16'h0800);
		pulse(7'h02);
		@(posedge clk_in) stall <= 0;
		wt(0);
		@(posedge clk_in) stall <= 1;
		@(posedge clk_in) app_lock_bit_in <= 0;
		wt(0);
		@(posedge clk_in) stall <= 0;
		wt(1);
		chk("enable", {15'h0000, global_enable_out}, 16'h0000);
		chk("pending", {8'h00, pending_flags_out}, 16'h0000);
		chk("vector", {4'h0, vector_addr_out}, 16'h0804);
		chk("sp", stack_pointer_out, 16'h03FE);
		@(posedge clk_in) {is_level_in, irq_enable_in, level_cond_in} <= {8'h04, 8'h06, 8'h04};
		@(posedge clk_in) level_cond_in <= 0;
		pulse(7'h04);
		repeat (4) @(posedge clk_in);
		#1 chk("enable", {15'h0000, global_enable_out}, 16'h0001);
		chk("sp", stack_pointer_out, 16'h0400);
		wt(0);
		rd("status_register", 6'h3F, 8'h80);
		pulse(7'h01);
		@(posedge clk_in) {sleeping_in, level_cond_in} <= {1'b1, 8'h04};
		pulse(7'h02);
		wt(1);
		chk("sp", stack_pointer_out, 16'h03FE);
		chk("vector", {4'h0, vector_addr_out}, 16'h0806);
		results;
	end
endmodule
